// [design/eeprom_wp_ctrl.sv]
// serial eeprom write path: latch, page buffer, protection and self-timed write cycle
`default_nettype none
module eeprom_wp_ctrl
    import eeprom_wp_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic wp_n,
    output logic so,
    output logic so_oe_n
);
    pins_s pins_in;
    pins_s s1_r, s2_r, s3_r, filt_r, prev_r;
    frame_e state_r;
    logic [7:0] sh_r, cmd_r;
    logic [3:0] bit_cnt_r;
    logic [15:0] addr_r;
    logic [6:0] ptr_r;
    logic is_read_r, data_seen_r;
    logic [PAGE_BYTES-1:0] mask_r;
    logic [7:0] pbuf_r [0:PAGE_BYTES-1];
    logic [7:0] mem_r [0:65535];
    logic write_latch_flag_r, busy_r, kind_status_r;
    logic [BUSY_CNT_W-1:0] busy_cnt_r;
    logic [7:0] commit_idx_r;
    logic [8:0] page_r;
    logic [7:0] sr_pend_r;
    logic protect_pin_enable_r, block_protect_hi_r, block_protect_lo_r;
    logic [2:0] rd_bit_r;
    logic sck_rise, sck_fall, cs_rise, cs_fall, sel;
    logic [7:0] byte_in, status_w, out_byte;
    logic wr_byte_done, hw_prot, end_set, end_clr, go_write, go_status, done;

    assign pins_in = '{cs_n: cs_n, sck: sck, si: si, wp_n: wp_n};

    // three-stage sampling; a level is taken once stages two and three agree
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s1_r <= PINS_IDLE;
            s2_r <= PINS_IDLE;
            s3_r <= PINS_IDLE;
            filt_r <= PINS_IDLE;
            prev_r <= PINS_IDLE;
        end else begin
            s1_r <= pins_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
            prev_r <= filt_r;
        end
    end

    // edge events of the filtered pins
    assign sel = !filt_r.cs_n;
    assign sck_rise = sel && filt_r.sck && !prev_r.sck;
    assign sck_fall = sel && !filt_r.sck && prev_r.sck;
    assign cs_rise = filt_r.cs_n && !prev_r.cs_n;
    assign cs_fall = !filt_r.cs_n && prev_r.cs_n;
    assign byte_in = {sh_r[6:0], filt_r.si};
    assign wr_byte_done = sck_rise && state_r == ST_WRITE && bit_cnt_r[2:0] == 3'h7;

    // live status byte; bits 6..4 read as zero
    always_comb begin
        status_w = 8'h00;
        status_w[SR_PEN_BIT] = protect_pin_enable_r;
        status_w[SR_BPH_BIT] = block_protect_hi_r;
        status_w[SR_BPL_BIT] = block_protect_lo_r;
        status_w[SR_WEL_BIT] = write_latch_flag_r;
        status_w[SR_WIP_BIT] = busy_r;
    end

    // frame-end decisions, taken on the chip select rise, and the end of the self-timed cycle
    assign hw_prot = !filt_r.wp_n && protect_pin_enable_r;
    assign end_set = cs_rise && state_r == ST_CMD_DONE && cmd_r == OP_LATCH_SET;
    assign end_clr = cs_rise && state_r == ST_CMD_DONE && cmd_r == OP_LATCH_CLEAR;
    assign go_write = cs_rise && state_r == ST_WRITE && bit_cnt_r[2:0] == 3'h0 && data_seen_r
        && write_latch_flag_r && !busy_r
        && !block_protected({block_protect_hi_r, block_protect_lo_r}, addr_r);
    assign go_status = cs_rise && state_r == ST_STAT_DONE && write_latch_flag_r && !busy_r && !hw_prot;
    assign done = busy_r && busy_cnt_r == BUSY_CNT_W'(WRITE_CYCLES - 1);

    // frame parser: opcode, address and data phases
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_IDLE;
            sh_r <= 8'h00;
            cmd_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            addr_r <= 16'h0000;
            ptr_r <= 7'h00;
            is_read_r <= 1'b0;
            data_seen_r <= 1'b0;
            mask_r <= '0;
        end else if (cs_fall) begin
            state_r <= ST_CMD;
            bit_cnt_r <= 4'h0;
            data_seen_r <= 1'b0;
        end else if (cs_rise) begin
            state_r <= ST_IDLE;
        end else if (sck_rise) begin
            unique case (state_r)
                ST_CMD: begin
                    sh_r <= byte_in;
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                    if (bit_cnt_r == 4'h7) begin
                        cmd_r <= byte_in;
                        bit_cnt_r <= 4'h0;
                        // a busy device answers nothing but the status read
                        if (busy_r && byte_in != OP_STATUS_READ) begin
                            state_r <= ST_IGNORE;
                        end else begin
                            unique case (byte_in)
                                OP_LATCH_SET, OP_LATCH_CLEAR: state_r <= ST_CMD_DONE;
                                OP_STATUS_READ: state_r <= ST_STAT_RD;
                                OP_STATUS_WRITE: state_r <= ST_STAT_WR;
                                OP_DATA_WRITE: begin
                                    state_r <= ST_ADDR;
                                    is_read_r <= 1'b0;
                                    mask_r <= '0;
                                end
                                OP_DATA_READ: begin
                                    state_r <= ST_ADDR;
                                    is_read_r <= 1'b1;
                                end
                                default: state_r <= ST_IGNORE;
                            endcase
                        end
                    end
                end
                ST_ADDR: begin
                    addr_r <= {addr_r[14:0], filt_r.si};
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                    if (bit_cnt_r == 4'hf) begin
                        state_r <= is_read_r ? ST_READ : ST_WRITE;
                        ptr_r <= {addr_r[5:0], filt_r.si};
                    end
                end
                ST_WRITE: begin
                    sh_r <= byte_in;
                    bit_cnt_r <= {1'b0, bit_cnt_r[2:0] + 3'h1};
                    if (wr_byte_done) begin
                        mask_r[ptr_r] <= 1'b1;
                        ptr_r <= ptr_r + 7'h01;
                        data_seen_r <= 1'b1;
                    end
                end
                ST_STAT_WR: begin
                    sh_r <= byte_in;
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                    if (bit_cnt_r == 4'h7) begin
                        state_r <= ST_STAT_DONE;
                    end
                end
                // extra bits spoil a finished latch instruction or status write
                ST_CMD_DONE, ST_STAT_DONE: state_r <= ST_IGNORE;
                ST_IDLE, ST_READ, ST_STAT_RD, ST_IGNORE: state_r <= state_r;
            endcase
        end else if (sck_fall && state_r == ST_READ && rd_bit_r == 3'h7) begin
            addr_r <= addr_r + 16'h0001;
        end
    end

    // page buffer holds the frame's bytes until the cycle commits them
    always_ff @(posedge sys_clk) begin
        if (wr_byte_done) begin
            pbuf_r[ptr_r] <= byte_in;
        end
    end

    // write enable latch
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            write_latch_flag_r <= 1'b0;
        end else if (end_set) begin
            write_latch_flag_r <= 1'b1;
        end else if (end_clr || done) begin
            write_latch_flag_r <= 1'b0;
        end
    end

    // self-timed cycle; the page is swept in its first 128 cycles
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            busy_r <= 1'b0;
            kind_status_r <= 1'b0;
            busy_cnt_r <= '0;
            commit_idx_r <= 8'h00;
            page_r <= 9'h000;
            sr_pend_r <= 8'h00;
        end else if (go_write || go_status) begin
            busy_r <= 1'b1;
            kind_status_r <= go_status;
            busy_cnt_r <= '0;
            commit_idx_r <= 8'h00;
            page_r <= addr_r[15:7];
            sr_pend_r <= sh_r;
        end else if (busy_r) begin
            busy_cnt_r <= busy_cnt_r + BUSY_CNT_W'(1);
            if (!commit_idx_r[7]) begin
                commit_idx_r <= commit_idx_r + 8'h01;
            end
            if (done) begin
                busy_r <= 1'b0;
            end
        end
    end

    // erase and program in one pass; untouched bytes are refreshed with old data
    always_ff @(posedge sys_clk) begin
        if (busy_r && !kind_status_r && !commit_idx_r[7]) begin
            mem_r[{page_r, commit_idx_r[6:0]}] <= mask_r[commit_idx_r[6:0]]
                ? pbuf_r[commit_idx_r[6:0]] : mem_r[{page_r, commit_idx_r[6:0]}];
        end
    end

    // retained status bits; only a finished status write changes them
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            protect_pin_enable_r <= PEN_RESET;
            block_protect_hi_r <= BP_RESET[1];
            block_protect_lo_r <= BP_RESET[0];
        end else if (done && kind_status_r) begin
            protect_pin_enable_r <= sr_pend_r[SR_PEN_BIT];
            block_protect_hi_r <= sr_pend_r[SR_BPH_BIT];
            block_protect_lo_r <= sr_pend_r[SR_BPL_BIT];
        end
    end

    // serial output, shifted after each falling clock edge
    assign out_byte = (state_r == ST_STAT_RD) ? status_w : mem_r[addr_r];
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_bit_r <= 3'h0;
            so <= 1'b0;
            so_oe_n <= 1'b1;
        end else begin
            so_oe_n <= !(sel && (state_r == ST_STAT_RD || state_r == ST_READ));
            if (cs_fall) begin
                rd_bit_r <= 3'h0;
            end else if (sck_fall && (state_r == ST_STAT_RD || state_r == ST_READ)) begin
                so <= out_byte[3'h7 - rd_bit_r];
                rd_bit_r <= rd_bit_r + 3'h1;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_latch_set;
        end_set |=> write_latch_flag_r ##1 write_latch_flag_r;
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch not set after latch-set frame");

    property p_latch_rise_cause;
        $rose(write_latch_flag_r) |-> $past(cs_rise && state_r == ST_CMD_DONE && cmd_r == OP_LATCH_SET);
    endproperty
    a_latch_rise_cause: assert property (p_latch_rise_cause) else $error("latch set without clean frame");

    property p_latch_clear;
        end_clr && !end_set |=> !write_latch_flag_r;
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("latch-clear ignored");

    property p_wrap;
        wr_byte_done && ptr_r == PAGE_LAST |=> ptr_r == 7'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("page pointer did not wrap");

    // judged from the registered page at launch, so a wrong gate term cannot hide behind itself
    property p_write_gate;
        $rose(busy_r) && !kind_status_r |-> $past(write_latch_flag_r) && $past(data_seen_r)
            && !block_protected({block_protect_hi_r, block_protect_lo_r}, {page_r, 7'h00});
    endproperty
    a_write_gate: assert property (p_write_gate) else $error("write launched illegally");

    property p_busy_start;
        $rose(busy_r) |-> $past(go_write || go_status);
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("cycle started without valid frame");

    property p_busy_end;
        done |=> !busy_r && !write_latch_flag_r && status_w[SR_WIP_BIT] == 1'b0;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("cycle end did not clear busy and latch");

    property p_no_read_busy;
        state_r == ST_READ |-> !busy_r;
    endproperty
    a_no_read_busy: assert property (p_no_read_busy) else $error("array read served during cycle");

    property p_hw_prot;
        $rose(busy_r) && kind_status_r |-> $past(filt_r.wp_n) || !$past(protect_pin_enable_r);
    endproperty
    a_hw_prot: assert property (p_hw_prot) else $error("status write under hardware protection");

    c_page_write: cover property (go_write ##[1:300] busy_r);
    c_status_write: cover property (go_status);
    c_cycle_done: cover property (done && !kind_status_r);
    c_status_busy: cover property (state_r == ST_STAT_RD && busy_r);
endmodule : eeprom_wp_ctrl
`default_nettype wire

// [design/eeprom_wp_pkg.sv]
// constants, pin carrier, frame states and protection decode for the eeprom write controller
`default_nettype none
package eeprom_wp_pkg;
    // instruction codes, sent msb first
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_DATA_WRITE = 8'h02;
    localparam logic [7:0] OP_DATA_READ = 8'h03;
    // protection_status field positions
    localparam int SR_PEN_BIT = 7;
    localparam int SR_BPH_BIT = 3;
    localparam int SR_BPL_BIT = 2;
    localparam int SR_WEL_BIT = 1;
    localparam int SR_WIP_BIT = 0;
    localparam logic [1:0] BP_RESET = 2'h0;
    localparam logic PEN_RESET = 1'b0;
    // geometry
    localparam int PAGE_BYTES = 128;
    localparam logic [6:0] PAGE_LAST = 7'h7f;
    localparam logic [15:0] QUARTER_BASE = 16'hc000;
    localparam logic [15:0] HALF_BASE = 16'h8000;
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    // self-timed cycle: 5 ms at a 50 ns clock
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_WRITE_MS = 5;
    localparam int WRITE_CYCLES_DEF = T_WRITE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BUSY_CNT_W = 17;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic wp_n;
    } pins_s;
    localparam pins_s PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};

    typedef enum {
        ST_IDLE, ST_CMD, ST_CMD_DONE, ST_ADDR, ST_WRITE, ST_READ,
        ST_STAT_WR, ST_STAT_DONE, ST_STAT_RD, ST_IGNORE
    } frame_e;

    // array address falls in a block guarded by the block-protect bits
    function automatic logic block_protected(input logic [1:0] bp, input logic [15:0] addr);
        unique case (bp)
            BP_NONE: block_protected = 1'b0;
            BP_QUARTER: block_protected = (addr >= QUARTER_BASE);
            BP_HALF: block_protected = (addr >= HALF_BASE);
            default: block_protected = 1'b1;
        endcase
    endfunction : block_protected
endpackage : eeprom_wp_pkg
`default_nettype wire

// [verification/spi_host_model.sv]
// serial host model: shifts frames onto the link and gathers the device's answer
`default_nettype none
module spi_host_model
    import eeprom_wp_pkg::*;
#(
    parameter int HALF_CLKS = 6
) (
    input wire logic sys_clk,
    input wire logic so,
    input wire logic so_oe_n,
    output var pins_s pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [63:0] rx_sr;
    int oe_bits;

    // link idles deselected with the clock parked low
    initial begin
        pins = PINS_IDLE;
        rx_sr = '0;
        oe_bits = 0;
    end

    // one frame of nbits, msb first; half periods of six clocks leave room for the pin filter lag
    task automatic frame(input logic [47:0] v, input int nbits);
        int k;
        oe_bits = 0;
        @(posedge sys_clk);
        pins.cs_n <= 1'b0;
        for (k = 0; k < nbits; k++) begin
            pins.si <= (k < 48) ? v[47 - k] : 1'b0;
            repeat (HALF_CLKS) @(posedge sys_clk);
            // answer bits are only taken while the device really drives the line
            if (so_oe_n === 1'b0) begin
                rx_sr <= {rx_sr[62:0], so};
                oe_bits++;
            end
            pins.sck <= 1'b1;
            repeat (HALF_CLKS) @(posedge sys_clk);
            pins.sck <= 1'b0;
        end
        repeat (HALF_CLKS) @(posedge sys_clk);
        pins.cs_n <= 1'b1;
        pins.si <= ~pins.si; // released line must not look like held data
        repeat (HALF_CLKS + 2) @(posedge sys_clk);
    endtask : frame

    // protect pin level, changed on a clock edge like the other pins
    task automatic set_protect(input logic v);
        @(posedge sys_clk);
        pins.wp_n <= v;
    endtask : set_protect
endmodule : spi_host_model
`default_nettype wire

// [verification/test_eeprom_write_protect_ctrl.sv]
// self-checking bench for the eeprom write-protect controller
`default_nettype none
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module test_eeprom_write_protect_ctrl
    import eeprom_wp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // short self-timed cycle, still long enough to span one status poll and a refused read opcode
    localparam int unsigned WCYC = 400;
    logic sys_clk;
    logic reset;
    logic so;
    logic so_oe_n;
    pins_s pins;
    logic [7:0] sr;
    int fail_count;
    int samples_checked;
    logic [15:0] addrs [6] = '{16'h0000, 16'h7fff, 16'h8000, 16'hbfff, 16'hc000, 16'hffff};

    eeprom_wp_ctrl #(.WRITE_CYCLES(WCYC)) dut (.sys_clk(sys_clk), .reset(reset), .cs_n(pins.cs_n),
        .sck(pins.sck), .si(pins.si), .wp_n(pins.wp_n), .so(so), .so_oe_n(so_oe_n));
    spi_host_model host (.sys_clk(sys_clk), .so(so), .so_oe_n(so_oe_n), .pins(pins));

    // 50 ns system clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic op(input logic [7:0] code, input int nbits);
        host.frame({code, 40'h0}, nbits);
    endtask : op

    task automatic status_read_cmd(output logic [7:0] v);
        host.frame({OP_STATUS_READ, 40'h0}, 16);
        v = host.rx_sr[7:0];
    endtask : status_read_cmd

    // bounded poll of the busy bit; running out ends the run
    task automatic wait_idle();
        logic [7:0] v;
        int n;
        for (n = 0; n < 20; n++) begin
            status_read_cmd(v);
            if (v[SR_WIP_BIT] === 1'b0) break;
        end
        if (n == 20) begin
            fail_count++;
            tally_and_finish();
        end
    endtask : wait_idle

    task automatic swr(input logic [7:0] v);
        op(OP_LATCH_SET, 8);
        host.frame({OP_STATUS_WRITE, v, 32'h0}, 16);
        wait_idle();
    endtask : swr

    task automatic wr(input logic [15:0] a, input logic [23:0] d, input int nbytes);
        op(OP_LATCH_SET, 8);
        host.frame({OP_DATA_WRITE, a, d}, 24 + 8 * nbytes);
    endtask : wr

    task automatic set_wp(input logic v);
        host.set_protect(v);
    endtask : set_wp

    // expected block protection, worked out from the upper address bits
    function automatic logic prot(input logic [1:0] bp, input logic [15:0] a);
        return (bp == 2'h3) || (bp == 2'h2 && a[15]) || (bp == 2'h1 && a[15:14] == 2'h3);
    endfunction : prot

    initial begin
        reset = 1'b1;
        fail_count = 0;
        samples_checked = 0;
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (6) @(posedge sys_clk);
        // latch handling, including frames that must not set it
        status_read_cmd(sr);
        `CHECK(sr, 8'h00)
        op(OP_LATCH_SET, 8);
        status_read_cmd(sr);
        `CHECK(sr, 8'h02)
        op(OP_LATCH_CLEAR, 8);
        status_read_cmd(sr);
        `CHECK(sr, 8'h00)
        op(OP_LATCH_SET, 9);
        status_read_cmd(sr);
        `CHECK(sr, 8'h00)
        host.frame({OP_LATCH_SET, OP_DATA_WRITE, 16'h0010, 8'ha5}, 40);
        status_read_cmd(sr);
        `CHECK(sr, 8'h00)
        host.frame({OP_DATA_WRITE, 16'h0010, 8'ha5, 16'h0}, 32);
        status_read_cmd(sr);
        `CHECK(sr, 8'h00)
        $display("test latch finished");
        // partial page write that wraps, then readback of kept and wrapped bytes
        wr(16'h0001, 24'h5a0000, 1);
        wait_idle();
        wr(16'h007e, 24'h112233, 3);
        status_read_cmd(sr);
        `CHECK(sr, 8'h03)
        host.frame({OP_DATA_READ, 16'h007e, 24'h0}, 40);
        `CHECK(host.oe_bits, 0)
        wait_idle();
        status_read_cmd(sr);
        `CHECK(sr, 8'h00)
        host.frame({OP_DATA_READ, 16'h007e, 24'h0}, 40);
        `CHECK(host.rx_sr[15:0], 16'h1122)
        host.frame({OP_DATA_READ, 16'h0000, 24'h0}, 40);
        `CHECK(host.rx_sr[15:0], 16'h335a)
        $display("test page finished");
        // frames that end off a byte boundary or carry no data start nothing
        wr(16'h0100, 24'ha50000, 0);
        host.frame({OP_DATA_WRITE, 16'h0100, 8'ha5, 16'h0}, 28);
        status_read_cmd(sr);
        `CHECK(sr, 8'h02)
        op(OP_LATCH_CLEAR, 8);
        $display("test abort finished");
        // every block-protect code against addresses on both sides of each boundary
        for (int bp = 0; bp < 4; bp++) begin
            swr({4'h0, bp[1:0], 2'b00});
            status_read_cmd(sr);
            `CHECK(sr, {4'h0, bp[1:0], 2'b00})
            for (int i = 0; i < 6; i++) begin
                wr(addrs[i], 24'h3c0000, 1);
                status_read_cmd(sr);
                `CHECK(sr, {4'h0, bp[1:0], 1'b1, !prot(bp[1:0], addrs[i])})
                wait_idle();
            end
        end
        $display("test blocks finished");
        // hardware protection through the pin and the enable bit
        swr(8'h80);
        status_read_cmd(sr);
        `CHECK(sr, 8'h80)
        set_wp(1'b0);
        swr(8'h0c);
        status_read_cmd(sr);
        `CHECK(sr, 8'h82)
        op(OP_LATCH_CLEAR, 8);
        status_read_cmd(sr);
        `CHECK(sr, 8'h80)
        wr(16'h0200, 24'h770000, 1);
        status_read_cmd(sr);
        `CHECK(sr, 8'h83)
        wait_idle();
        set_wp(1'b1);
        swr(8'h00);
        set_wp(1'b0);
        swr(8'h04);
        status_read_cmd(sr);
        `CHECK(sr, 8'h04)
        $display("test pin finished");
        tally_and_finish();
    end
endmodule : test_eeprom_write_protect_ctrl
`default_nettype wire
